// *** shared/pfta_map.vh ***
`ifndef PFTA_MAP_VH
`define PFTA_MAP_VH
`define PFTA_A_CTRL 3'h0
`define PFTA_A_UNLOCK 3'h1
`define PFTA_A_LATCH 3'h2
`define PFTA_A_PTRL 3'h3
`define PFTA_A_PTRH 3'h4
`define PFTA_A_PTRU 3'h5
`define PFTA_A_EEPROM_DATA_REG 3'h6
`define PFTA_A_EEADDR 3'h7
`define PFTA_B_FLASH 7
`define PFTA_B_CFG 6
`define PFTA_B_ERASE 4
`define PFTA_B_ERR 3
`define PFTA_B_WRITE_ENABLE_BIT 2
`define PFTA_B_WR 1
`define PFTA_B_RD 0
`define PFTA_KEY1 8'h55
`define PFTA_KEY2 8'hAA
`define PFTA_CTRL_RST 8'h00
`define PFTA_CLK_MHZ 25
`define PFTA_LONG_US 2000
`define PFTA_LONG_CYC (`PFTA_LONG_US * `PFTA_CLK_MHZ)
`define PFTA_MODE_NONE 2'h0
`define PFTA_MODE_POSTINC 2'h1
`define PFTA_MODE_POSTDEC 2'h2
`define PFTA_MODE_PREINC 2'h3
`endif

// *** src/pfta_holding.v ***
`timescale 1ns/1ps
`default_nettype none
// eight byte holding registers, read data registered
module pfta_holding (
    input wire core_clk,
    input wire rst_sync_n,
    input wire wr_en,
    input wire [2:0] wr_idx,
    input wire [7:0] wr_data,
    input wire [2:0] rd_idx,
    output reg [7:0] rd_data
);
    reg [7:0] mem_q [0:7];
    genvar gi;
    // per-entry storage, set to erased value at reset
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_ent
            always @(posedge core_clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    mem_q[gi] <= 8'hFF;
                end else if (wr_en && wr_idx == gi) begin
                    mem_q[gi] <= wr_data;
                end
            end
        end
    endgenerate
    // registered read port
    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem_q[rd_idx];
        end
    end
endmodule // pfta_holding
`default_nettype wire

// *** src/pfta_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "pfta_map.vh"
// program flash table access unit
module pfta_top #(
    parameter LONG_CYC = `PFTA_LONG_CYC
) (
    input wire core_clk,
    input wire rst_n,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire table_read_instr,
    input wire table_write_instr,
    input wire [1:0] table_ptr_mode,
    output reg [21:0] mem_addr,
    output reg mem_rd,
    input wire [7:0] mem_rdata,
    output reg prog_start,
    output reg erase_start,
    output reg [63:0] prog_data,
    output reg eeprom_rd,
    output reg fetch_stall,
    output reg memory_write_done_flag
);
    localparam ST_IDLE = 2'h0;
    localparam ST_RDWAIT = 2'h1;
    localparam ST_LONG = 2'h2;
    localparam ST_DUMP = 2'h3;

    reg rst_m_q;
    reg rst_sync_n;
    reg [7:0] ctrl_q;
    reg [7:0] latch_q;
    reg [21:0] ptr_q;
    reg [7:0] eeprom_data_reg_q;
    reg [7:0] eeaddr_q;
    reg [1:0] unlock_q;
    reg [1:0] st_q;
    reg [31:0] cnt_q;
    reg [21:0] op_addr_q;
    reg [3:0] dump_q;
    reg busy_q;
    reg rd_was_q;
    reg pend_q;
    reg [1:0] keep_sel_q;
    reg first_q;
    wire [21:0] ptr_inc;
    wire [21:0] ptr_dec;
    wire [21:0] ptr_use;
    wire [7:0] hold_rd;
    wire hold_we;
    wire start_ok;
    wire set_wr;
    wire set_rd;

    // reset release through two flops
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_sync_n <= rst_m_q;
        end
    end

    // pointer arithmetic on low 21 bits only
    assign ptr_inc = {ptr_q[21], ptr_q[20:0] + 21'h000001};
    assign ptr_dec = {ptr_q[21], ptr_q[20:0] - 21'h000001};
    assign ptr_use = (table_ptr_mode == `PFTA_MODE_PREINC) ? ptr_inc : ptr_q;
    assign hold_we = table_write_instr && !busy_q;

    // write and read start qualifiers
    assign set_wr = reg_wr && reg_addr == `PFTA_A_CTRL && reg_wdata[`PFTA_B_WR];
    assign start_ok = set_wr && ctrl_q[`PFTA_B_WRITE_ENABLE_BIT] && unlock_q == 2'h2
        && !busy_q;
    assign set_rd = reg_wr && reg_addr == `PFTA_A_CTRL && reg_wdata[`PFTA_B_RD]
        && !reg_wdata[`PFTA_B_FLASH] && !busy_q;

    pfta_holding u_hold (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .wr_en(hold_we),
        .wr_idx(ptr_use[2:0]),
        .wr_data(latch_q),
        .rd_idx(dump_q[2:0]),
        .rd_data(hold_rd)
    );

    // unlock sequence tracker, port itself stores nothing
    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            unlock_q <= 2'h0;
        end else if (reg_wr && reg_addr == `PFTA_A_UNLOCK) begin
            if (reg_wdata == `PFTA_KEY1) begin
                unlock_q <= 2'h1;
            end else if (reg_wdata == `PFTA_KEY2 && unlock_q == 2'h1) begin
                unlock_q <= 2'h2;
            end else begin
                unlock_q <= 2'h0;
            end
        end else if (reg_wr || reg_rd) begin
            unlock_q <= 2'h0;
        end
    end

    // control, pointer, latch and eeprom registers
    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl_q <= `PFTA_CTRL_RST;
            latch_q <= 8'h00;
            ptr_q <= 22'h000000;
            eeprom_data_reg_q <= 8'h00;
            eeaddr_q <= 8'h00;
            first_q <= 1'b1;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `PFTA_A_CTRL: begin
                        ctrl_q[`PFTA_B_FLASH] <= reg_wdata[`PFTA_B_FLASH];
                        ctrl_q[`PFTA_B_CFG] <= reg_wdata[`PFTA_B_CFG];
                        ctrl_q[`PFTA_B_WRITE_ENABLE_BIT] <= reg_wdata[`PFTA_B_WRITE_ENABLE_BIT];
                        ctrl_q[`PFTA_B_ERR] <= reg_wdata[`PFTA_B_ERR];
                        if (!busy_q) begin
                            ctrl_q[`PFTA_B_ERASE] <= reg_wdata[`PFTA_B_ERASE];
                        end
                        if (start_ok) begin
                            ctrl_q[`PFTA_B_WR] <= 1'b1;
                        end
                        if (set_rd) begin
                            ctrl_q[`PFTA_B_RD] <= 1'b1;
                        end
                    end
                    `PFTA_A_LATCH: latch_q <= reg_wdata;
                    `PFTA_A_PTRL: ptr_q[7:0] <= reg_wdata;
                    `PFTA_A_PTRH: ptr_q[15:8] <= reg_wdata;
                    `PFTA_A_PTRU: ptr_q[21:16] <= reg_wdata[5:0];
                    `PFTA_A_EEPROM_DATA_REG: eeprom_data_reg_q <= reg_wdata;
                    `PFTA_A_EEADDR: eeaddr_q <= reg_wdata;
                    default: ;
                endcase
            end
            // read start finishes one cycle later
            if (ctrl_q[`PFTA_B_RD] && !set_rd) begin
                ctrl_q[`PFTA_B_RD] <= 1'b0;
            end
            // table read result into latch
            if (rd_was_q) begin
                latch_q <= mem_rdata;
            end
            // pointer update for table instructions
            if ((table_read_instr || table_write_instr) && !busy_q) begin
                case (table_ptr_mode)
                    `PFTA_MODE_POSTINC: ptr_q <= ptr_inc;
                    `PFTA_MODE_POSTDEC: ptr_q <= ptr_dec;
                    `PFTA_MODE_PREINC: ptr_q <= ptr_inc;
                    default: ptr_q <= ptr_q;
                endcase
            end
            // completion of a long operation
            if (st_q == ST_LONG && cnt_q == 32'h00000000) begin
                ctrl_q[`PFTA_B_WR] <= 1'b0;
                ctrl_q[`PFTA_B_ERASE] <= 1'b0;
            end
            // a reset that cut a long op: restore selects, flag the abort
            first_q <= 1'b0;
            if (first_q && pend_q) begin
                ctrl_q[7:6] <= keep_sel_q;
                ctrl_q[`PFTA_B_ERR] <= 1'b1;
            end
        end
    end

    // long operation sequencer
    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_q <= ST_IDLE;
            cnt_q <= 32'h00000000;
            op_addr_q <= 22'h000000;
            dump_q <= 4'h0;
            busy_q <= 1'b0;
            rd_was_q <= 1'b0;
            mem_addr <= 22'h000000;
            mem_rd <= 1'b0;
            prog_start <= 1'b0;
            erase_start <= 1'b0;
            prog_data <= 64'h0000000000000000;
            eeprom_rd <= 1'b0;
            fetch_stall <= 1'b0;
            memory_write_done_flag <= 1'b0;
        end else begin
            prog_start <= 1'b0;
            erase_start <= 1'b0;
            memory_write_done_flag <= 1'b0;
            mem_rd <= 1'b0;
            rd_was_q <= 1'b0;
            eeprom_rd <= set_rd;
            case (st_q)
                ST_IDLE: begin
                    if (table_read_instr) begin
                        mem_addr <= ptr_use;
                        mem_rd <= 1'b1;
                        st_q <= ST_RDWAIT;
                    end else if (start_ok) begin
                        busy_q <= 1'b1;
                        fetch_stall <= 1'b1;
                        if (ctrl_q[`PFTA_B_ERASE]) begin
                            op_addr_q <= {ptr_q[21:6], 6'h00};
                            mem_addr <= {ptr_q[21:6], 6'h00};
                            st_q <= ST_LONG;
                            cnt_q <= LONG_CYC - 1;
                            erase_start <= 1'b1;
                        end else begin
                            op_addr_q <= {ptr_q[21:3], 3'h0};
                            dump_q <= 4'h0;
                            st_q <= ST_DUMP;
                        end
                    end
                end
                ST_RDWAIT: begin
                    rd_was_q <= 1'b1;
                    st_q <= ST_IDLE;
                end
                ST_DUMP: begin
                    // gather holding bytes, one cycle read latency
                    dump_q <= dump_q + 4'h1;
                    if (dump_q != 4'h0) begin
                        prog_data <= {hold_rd, prog_data[63:8]};
                    end
                    if (dump_q == 4'h8) begin
                        mem_addr <= op_addr_q;
                        prog_start <= 1'b1;
                        cnt_q <= LONG_CYC - 1;
                        st_q <= ST_LONG;
                    end
                end
                ST_LONG: begin
                    mem_addr <= op_addr_q;
                    if (cnt_q == 32'h00000000) begin
                        busy_q <= 1'b0;
                        fetch_stall <= 1'b0;
                        memory_write_done_flag <= 1'b1;
                        st_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 32'h00000001;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // busy and select copies, frozen while reset is applied
    always @(posedge core_clk) begin
        if (rst_sync_n) begin
            pend_q <= busy_q;
            keep_sel_q <= ctrl_q[7:6];
        end
    end

    // register read port, data one cycle later
    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PFTA_A_CTRL: reg_rdata <= {ctrl_q[7:6], 1'b0, ctrl_q[4],
                    ctrl_q[3], ctrl_q[2:0]};
                `PFTA_A_UNLOCK: reg_rdata <= 8'h00;
                `PFTA_A_LATCH: reg_rdata <= latch_q;
                `PFTA_A_PTRL: reg_rdata <= ptr_q[7:0];
                `PFTA_A_PTRH: reg_rdata <= ptr_q[15:8];
                `PFTA_A_PTRU: reg_rdata <= {2'h0, ptr_q[21:16]};
                `PFTA_A_EEPROM_DATA_REG: reg_rdata <= eeprom_data_reg_q;
                `PFTA_A_EEADDR: reg_rdata <= eeaddr_q;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // pfta_top
`default_nettype wire

// *** sim/pfta_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// port-level checker for the table access unit
module pfta_chk #(
    parameter LONG_CYC = 20
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic table_read_instr,
    input wire logic mem_rd,
    input wire logic prog_start,
    input wire logic erase_start,
    input wire logic eeprom_rd,
    input wire logic fetch_stall,
    input wire logic memory_write_done_flag
);
    logic key1_q;
    logic armed_q;
    logic [15:0] stall_cnt_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // unlock sequence tracker and stall length counter
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            key1_q <= 1'b0;
            armed_q <= 1'b0;
            stall_cnt_q <= 16'h0;
        end else begin
            if (reg_wr || reg_rd) begin
                key1_q <= reg_wr && reg_addr == 3'h1 && reg_wdata == 8'h55;
                armed_q <= key1_q && reg_wr && reg_addr == 3'h1 && reg_wdata == 8'hAA;
            end
            stall_cnt_q <= fetch_stall ? stall_cnt_q + 16'h1 : 16'h0;
        end
    end
    AST_UNLOCK_ZERO: assert property (reg_rd && reg_addr == 3'h1 |=> reg_rdata == 8'h00)
        else $error("unlock port read not zero");
    AST_TABLE_READ_INSTR_FETCH: assert property (table_read_instr && !fetch_stall |=> mem_rd)
        else $error("table read gave no array read");
    AST_NO_FETCH_BUSY: assert property (fetch_stall |-> !mem_rd)
        else $error("array read while stalled");
    AST_STALL_START: assert property ($rose(fetch_stall) |-> ##[0:10] (prog_start || erase_start))
        else $error("stall without a start pulse");
    AST_DONE_AFTER: assert property (memory_write_done_flag |-> $past(fetch_stall))
        else $error("done flag outside a long op");
    AST_LOCKED: assert property (reg_wr && reg_addr == 3'h0 && reg_wdata[1] && !armed_q
        && !fetch_stall |=> !fetch_stall [*2])
        else $error("start accepted without unlock");
    AST_EE_FLASH: assert property (reg_wr && reg_addr == 3'h0 && reg_wdata[7] && reg_wdata[0]
        |=> !eeprom_rd [*2])
        else $error("read start taken with flash selected");
    AST_STALL_MIN: assert property ($fell(fetch_stall) |-> stall_cnt_q >= LONG_CYC)
        else $error("stall shorter than timer");
endmodule // pfta_chk
bind pfta_top pfta_chk #(.LONG_CYC(LONG_CYC)) u_chk (.core_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .table_read_instr, .mem_rd, .prog_start, .erase_start,
    .eeprom_rd, .fetch_stall, .memory_write_done_flag);
`default_nettype wire

// *** sim/pfta_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// flash array: one byte per read, pattern from all 22 address bits
module pfta_flash_model (
    input wire logic core_clk,
    input wire logic mem_rd,
    input wire logic [21:0] mem_addr,
    output logic [7:0] mem_rdata
);
    initial mem_rdata = 8'h00;
    // data stands only in the cycle after the read strobe
    always @(posedge core_clk) begin
        if (mem_rd) begin
            mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ {2'h0, mem_addr[21:16]};
        end else begin
            mem_rdata <= ~mem_rdata; // stale data keeps changing
        end
    end
endmodule // pfta_flash_model
`default_nettype wire

// *** sim/tb_program_flash_table_access.sv ***
`timescale 1ns/1ps
`default_nettype none
// register-level bench for the table access unit
module tb_program_flash_table_access;
    logic core_clk, rst_n, reg_wr, reg_rd, trd, twr, mem_rd, prog_start, erase_start;
    logic eeprom_rd, fetch_stall, done;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, mem_rdata, d;
    logic [1:0] mode;
    logic [21:0] mem_addr, cap_addr;
    logic [63:0] prog_data, cap_data, e64;
    logic [1:0] ms[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [21:0] ra[4] = '{22'h3FFFFF, 22'h200000, 22'h200000, 22'h200000};
    logic [21:0] np[4] = '{22'h200000, 22'h3FFFFF, 22'h200000, 22'h200000};
    int errors = 0, cmp_count = 0, cyc = 0, n_prog = 0, n_erase = 0, n_ee = 0, n_done = 0, i;
    pfta_top #(.LONG_CYC(20)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .table_read_instr(trd), .table_write_instr(twr), .table_ptr_mode(mode),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .prog_start(prog_start),
        .erase_start(erase_start), .prog_data(prog_data), .eeprom_rd(eeprom_rd),
        .fetch_stall(fetch_stall), .memory_write_done_flag(done));
    pfta_flash_model u_mem (.core_clk(core_clk), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // pulse counters, start capture and run limit
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (prog_start) begin
            n_prog <= n_prog + 1;
            cap_data <= prog_data;
        end
        if (prog_start || erase_start) cap_addr <= mem_addr;
        if (erase_start) n_erase <= n_erase + 1;
        if (eeprom_rd) n_ee <= n_ee + 1;
        if (done) n_done <= n_done + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            report_and_stop;
        end
    end
    function automatic logic [7:0] ef(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]};
    endfunction
    task chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [2:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task setp(input logic [21:0] p);
        wr(3'h3, p[7:0]);
        wr(3'h4, p[15:8]);
        wr(3'h5, {2'h0, p[21:16]});
    endtask
    task chkp(input logic [21:0] p);
        rd(3'h3);
        chk(d, p[7:0]);
        rd(3'h4);
        chk(d, p[15:8]);
        rd(3'h5);
        chk(d[5:0], p[21:16]);
    endtask
    task tbl(input logic r, input logic [1:0] m);
        @(posedge core_clk);
        trd <= r;
        twr <= !r;
        mode <= m;
        @(posedge core_clk);
        trd <= 1'b0;
        twr <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    task longop(input logic [7:0] c);
        int n0;
        n0 = n_done;
        wr(3'h1, 8'h55);
        wr(3'h1, 8'hAA);
        wr(3'h0, c);
        wr(3'h0, c & 8'hF9);
        for (int k = 0; k < 200 && n_done == n0; k++) @(posedge core_clk);
        repeat (3) @(posedge core_clk);
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        {reg_wr, reg_rd, trd, twr, mode} = 6'h00;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(3'h0);
        chk(d, 8'h00);
        wr(3'h1, 8'h55);
        rd(3'h1);
        chk(d, 8'h00);
        $display("test reset done");
        // every pointer mode, the three moving ones across the 21-bit wrap in config space
        setp(22'h3FFFFF);
        for (i = 0; i < 4; i++) begin
            tbl(1'b1, ms[i]);
            rd(3'h2);
            chk(d, ef(ra[i]));
            chkp(np[i]);
        end
        $display("test table read done");
        // eight writes starting mid-block, then refused starts
        setp(22'h00123A);
        for (i = 0; i < 8; i++) begin
            wr(3'h2, 8'hA0 + i[7:0]);
            tbl(1'b0, 2'h1);
            e64[8 * ((i + 2) % 8) +: 8] = 8'hA0 + i[7:0];
        end
        wr(3'h0, 8'h80);
        wr(3'h1, 8'h55);
        wr(3'h1, 8'hAA);
        wr(3'h0, 8'h82);
        wr(3'h0, 8'h86);
        repeat (15) @(posedge core_clk);
        chk(n_prog, 0);
        rd(3'h0);
        chk(d[1], 1'b0);
        longop(8'h86);
        chk(n_prog, 1);
        chk(cap_addr[21:3], 19'h00248);
        chk(cap_data, e64);
        rd(3'h0);
        chk({d[7], d[2], d[1]}, 3'b100);
        chk(n_done, 1);
        $display("test block write done");
        setp(22'h0013C5);
        wr(3'h0, 8'h94);
        longop(8'h96);
        chk({n_erase, n_prog}, {32'h1, 32'h1});
        chk(cap_addr[21:6], 16'h004F);
        chk(n_done, 2);
        rd(3'h0);
        chk({d[4], d[1]}, 2'b00);
        $display("test erase done");
        wr(3'h0, 8'h01);
        repeat (3) @(posedge core_clk);
        chk(n_ee, 1);
        rd(3'h0);
        chk(d[0], 1'b0);
        wr(3'h0, 8'h81);
        repeat (3) @(posedge core_clk);
        chk(n_ee, 1);
        $display("test read start done");
        // reset in the middle of a block write, before its timed phase starts
        wr(3'h6, 8'h5A);
        wr(3'h7, 8'h3C);
        wr(3'h0, 8'h84);
        wr(3'h1, 8'h55);
        wr(3'h1, 8'hAA);
        wr(3'h0, 8'h86);
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(3'h0);
        chk({d[7:6], d[3]}, 3'b101);
        rd(3'h6);
        chk(d, 8'h00);
        rd(3'h7);
        chk(d, 8'h00);
        $display("test reset abort done");
        report_and_stop;
    end
endmodule // tb_program_flash_table_access
`default_nettype wire
